// ===== rtl/ee_device.sv
`timescale 1ns/10ps
`default_nettype none
module ee_device #(
  parameter int unsigned WRITE_CYCLES = ee_pkg::TWC_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic sup_rst,
  output logic busy,
  ee_link_if.device link
);
  ee_pkg::ee_dev_state_type state_reg;
  logic [1:0] scl_sync_reg, sda_sync_reg, sup_sync_reg, done_sync_reg, go_sync_reg;
  logic scl_prev_reg, sda_prev_reg, done_prev_reg, go_prev_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg;
  logic tx_act_reg, ack_reg, mack_reg, wr_pend_reg, sda_low_reg;
  logic [ee_pkg::PAGE_BYTES-1:0] pval_reg;
  logic prog_busy_reg, go_tgl_reg, done_tgl_reg, busy_reg;
  logic [31:0] timer_reg;
  logic [7:0] mem [ee_pkg::MEM_BYTES];
  logic [7:0] page_mem [ee_pkg::PAGE_BYTES];

  // Link-side decode
  wire scl_now = scl_sync_reg[1];
  wire sda_now = sda_sync_reg[1];
  wire sup_now = sup_sync_reg[1];
  wire start_det = scl_now & scl_prev_reg & sda_prev_reg & ~sda_now;
  wire stop_det = scl_now & scl_prev_reg & ~sda_prev_reg & sda_now;
  wire scl_rise = scl_now & ~scl_prev_reg;
  wire scl_fall = ~scl_now & scl_prev_reg;
  wire in_read = state_reg == ee_pkg::DS_READ;
  wire rx_state = (state_reg == ee_pkg::DS_CTRL) | (state_reg == ee_pkg::DS_WADDR) |
                  (state_reg == ee_pkg::DS_WDATA);
  wire byte_done = scl_fall & rx_state & (cnt_reg == ee_pkg::ACK_BIT) & ~ack_reg;
  wire slot_end = scl_fall & (cnt_reg == ee_pkg::SLOT_END);
  wire addr_hit = (shift_reg[7:4] == ee_pkg::DEV_TYPE) & ~prog_busy_reg & ~sup_now;
  wire ctrl_done = byte_done & (state_reg == ee_pkg::DS_CTRL);
  wire waddr_done = byte_done & (state_reg == ee_pkg::DS_WADDR);
  wire data_take = byte_done & (state_reg == ee_pkg::DS_WDATA);
  wire commit_now = stop_det & (state_reg == ee_pkg::DS_WDATA) & wr_pend_reg &
                    ~sup_now & ~prog_busy_reg;
  wire done_seen = done_sync_reg[1] ^ done_prev_reg;
  wire [7:0] mem_rd = mem[ptr_reg];
  wire drive_next = ~sup_now & (ack_reg | (in_read & tx_act_reg & ~tx_reg[7]));

  assign link.s_sda_out = 1'b0;
  assign link.s_sda_oe = sda_low_reg;
  assign busy = busy_reg;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sup_sync_reg <= 2'h0;
      done_sync_reg <= 2'h0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      done_prev_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], link.scl};
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
      sup_sync_reg <= {sup_sync_reg[0], sup_rst};
      done_sync_reg <= {done_sync_reg[0], done_tgl_reg};
      scl_prev_reg <= scl_now;
      sda_prev_reg <= sda_now;
      done_prev_reg <= done_sync_reg[1];
      sda_low_reg <= drive_next;
    end
  end

  // Bus engine
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ee_pkg::DS_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= ee_pkg::PTR_RST;
      tx_act_reg <= 1'b0;
      ack_reg <= 1'b0;
      mack_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      pval_reg <= '0;
    end else if (sup_now) begin
      state_reg <= ee_pkg::DS_IDLE;
      ack_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ee_pkg::DS_CTRL;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ee_pkg::DS_IDLE;
      ack_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
    end else begin
      if (scl_rise && state_reg != ee_pkg::DS_IDLE) begin
        if (cnt_reg != ee_pkg::SLOT_END) begin
          cnt_reg <= cnt_reg + 4'h1;
        end
        if (rx_state && cnt_reg < ee_pkg::ACK_BIT) begin
          shift_reg <= {shift_reg[6:0], sda_now};
        end
        if (in_read && cnt_reg == ee_pkg::ACK_BIT && !ack_reg) begin
          mack_reg <= ~sda_now;
        end
      end
      if (ctrl_done) begin
        if (addr_hit) begin
          ack_reg <= 1'b1;
          state_reg <= shift_reg[0] ? ee_pkg::DS_READ : ee_pkg::DS_WADDR;
        end else begin
          state_reg <= ee_pkg::DS_IDLE;
        end
      end
      if (waddr_done) begin
        ack_reg <= 1'b1;
        ptr_reg <= shift_reg;
        pval_reg <= '0;
        state_reg <= ee_pkg::DS_WDATA;
      end
      if (data_take) begin
        ack_reg <= 1'b1;
        pval_reg[ptr_reg[3:0]] <= 1'b1;
        ptr_reg[3:0] <= ptr_reg[3:0] + 4'h1;
        wr_pend_reg <= 1'b1;
      end
      if (scl_fall && in_read && tx_act_reg) begin
        if (cnt_reg == ee_pkg::ACK_BIT) begin
          tx_act_reg <= 1'b0;
        end else if (cnt_reg != 4'h0) begin
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
      if (slot_end) begin
        ack_reg <= 1'b0;
        cnt_reg <= 4'h0;
        if (in_read) begin
          if (ack_reg || mack_reg) begin
            tx_reg <= mem_rd;
            ptr_reg <= ptr_reg + 8'h01;
            tx_act_reg <= 1'b1;
          end else begin
            state_reg <= ee_pkg::DS_WAITP;
          end
        end
      end
    end
  end

  // Page buffer and array; only the page bytes received in the write land at the stop
  always_ff @(posedge link_clk) begin
    if (data_take) begin
      page_mem[ptr_reg[3:0]] <= shift_reg;
    end
    if (commit_now) begin
      for (int i = 0; i < ee_pkg::PAGE_BYTES; i++) begin
        if (pval_reg[i]) begin
          mem[{ptr_reg[7:4], 4'(i)}] <= page_mem[i];
        end
      end
    end
  end

  // Programming cycle: launched on the link side, timed on the system clock
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      prog_busy_reg <= 1'b0;
      go_tgl_reg <= 1'b0;
    end else if (commit_now) begin
      prog_busy_reg <= 1'b1;
      go_tgl_reg <= ~go_tgl_reg;
    end else if (done_seen) begin
      prog_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      go_sync_reg <= 2'h0;
      go_prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      timer_reg <= 32'h0;
      done_tgl_reg <= 1'b0;
    end else begin
      go_sync_reg <= {go_sync_reg[0], go_tgl_reg};
      go_prev_reg <= go_sync_reg[1];
      if (go_sync_reg[1] ^ go_prev_reg) begin
        busy_reg <= 1'b1;
        timer_reg <= 32'(WRITE_CYCLES - 1);
      end else if (busy_reg) begin
        if (timer_reg == 32'h0) begin
          busy_reg <= 1'b0;
          done_tgl_reg <= ~done_tgl_reg;
        end else begin
          timer_reg <= timer_reg - 32'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ee_pkg.sv
package ee_pkg;

  // Device-type code compared with the top nibble of the address byte
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] SLOT_END = 4'h9;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 256;

  // Timing at the 200 MHz system clock
  localparam int CLK_KHZ = 200000;
  localparam int TWC_MS = 5;
  localparam int TWC_CYCLES = TWC_MS * CLK_KHZ;
  localparam int SCL_KHZ = 400;
  localparam int QTR_CYCLES = CLK_KHZ / (SCL_KHZ * 4);

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_CTRL = 3'h1,
    DS_WADDR = 3'h2,
    DS_WDATA = 3'h3,
    DS_READ = 3'h4,
    DS_WAITP = 3'h5
  } ee_dev_state_type;

  typedef enum logic [2:0] {
    MS_IDLE = 3'h0,
    MS_START = 3'h1,
    MS_TX = 3'h2,
    MS_RX = 3'h3,
    MS_STOP = 3'h4
  } ee_mst_state_type;

  typedef enum logic [1:0] {
    STEP_CTRL1 = 2'h0,
    STEP_ADDR = 2'h1,
    STEP_DATA = 2'h2,
    STEP_CTRL2 = 2'h3
  } ee_step_type;

  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_READ_CUR = 2'h1,
    CMD_READ_RAND = 2'h2,
    CMD_POLL = 2'h3
  } ee_cmd_type;

endpackage

// ===== rtl/ee_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ee_link_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  logic sda;

  // Open-drain wired AND with pull-up
  assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

  modport master (output scl, output m_sda_out, output m_sda_oe, input sda);
  modport device (input scl, input sda, output s_sda_out, output s_sda_oe);
endinterface
`default_nettype wire

// ===== rtl/ee_master.sv
`timescale 1ns/10ps
`default_nettype none
module ee_master (
  input wire logic clk,
  input wire logic rst,
  ee_link_if.master link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_addr,
  input wire logic [3:0] cmd_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack
);
  ee_pkg::ee_mst_state_type state_reg;
  ee_pkg::ee_step_type step_reg;
  ee_pkg::ee_cmd_type kind_reg;
  logic [7:0] div_reg, tx_reg, rx_reg, addr_reg, rd_data_reg;
  logic [1:0] q_reg, sda_sync_reg;
  logic [3:0] bcnt_reg, left_reg;
  logic scl_reg, sda_low_reg, rd_valid_reg, done_reg, nack_reg;

  wire sda_in = sda_sync_reg[1];
  wire tick = div_reg == 8'(ee_pkg::QTR_CYCLES - 1);
  wire unit_end = tick & (q_reg == 2'h3);
  wire is_write = kind_reg == ee_pkg::CMD_WRITE;
  wire ack_slot = bcnt_reg == ee_pkg::ACK_BIT;
  wire acked = ~sda_in;
  wire tx_end = unit_end & (state_reg == ee_pkg::MS_TX) & ack_slot & acked;
  wire take_first = tx_end & (step_reg == ee_pkg::STEP_ADDR) & is_write;
  wire take_more = tx_end & (step_reg == ee_pkg::STEP_DATA) & (left_reg != 4'h0);
  wire scl_want = (state_reg == ee_pkg::MS_IDLE) | q_reg[1];
  wire start_ctrl = (state_reg == ee_pkg::MS_START) & (q_reg == 2'h3);
  wire stop_ctrl = (state_reg == ee_pkg::MS_STOP) & (q_reg != 2'h3);
  wire tx_ctrl = (state_reg == ee_pkg::MS_TX) & ~ack_slot & ~tx_reg[7];
  wire rx_ctrl = (state_reg == ee_pkg::MS_RX) & ack_slot & (left_reg != 4'h0);
  wire sda_want = start_ctrl | stop_ctrl | tx_ctrl | rx_ctrl;

  assign cmd_ready = state_reg == ee_pkg::MS_IDLE;
  assign wr_take = take_first | take_more;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign done = done_reg;
  assign nack = nack_reg;
  assign link.scl = scl_reg;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe = sda_low_reg;

  // Pin sampling and line drivers; SDA moves while SCL is low, except at start and stop, where it moves with SCL high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_sync_reg <= 2'h3;
      scl_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
      scl_reg <= scl_want;
      if (q_reg != 2'h0 || state_reg == ee_pkg::MS_IDLE) begin
        sda_low_reg <= sda_want;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
      q_reg <= 2'h0;
    end else if (state_reg == ee_pkg::MS_IDLE || tick) begin
      div_reg <= 8'h00;
      q_reg <= (state_reg == ee_pkg::MS_IDLE) ? 2'h0 : q_reg + 2'h1;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ee_pkg::MS_IDLE;
      step_reg <= ee_pkg::STEP_CTRL1;
      kind_reg <= ee_pkg::CMD_WRITE;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      addr_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      bcnt_reg <= 4'h0;
      left_reg <= 4'h0;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      if (state_reg == ee_pkg::MS_IDLE) begin
        if (cmd_valid) begin
          kind_reg <= ee_pkg::ee_cmd_type'(cmd_kind);
          addr_reg <= cmd_addr;
          left_reg <= cmd_len;
          nack_reg <= 1'b0;
          step_reg <= ee_pkg::STEP_CTRL1;
          state_reg <= ee_pkg::MS_START;
        end
      end else if (unit_end) begin
        unique case (state_reg)
          ee_pkg::MS_START: begin
            state_reg <= ee_pkg::MS_TX;
            bcnt_reg <= 4'h0;
            tx_reg <= {ee_pkg::DEV_TYPE, 3'h0,
              (kind_reg == ee_pkg::CMD_READ_CUR) | (step_reg == ee_pkg::STEP_CTRL2)};
          end
          ee_pkg::MS_TX: begin
            bcnt_reg <= ack_slot ? 4'h0 : bcnt_reg + 4'h1;
            if (!ack_slot) begin
              tx_reg <= {tx_reg[6:0], 1'b0};
            end else if (!acked) begin
              nack_reg <= 1'b1;
              state_reg <= ee_pkg::MS_STOP;
            end else begin
              unique case (step_reg)
                ee_pkg::STEP_CTRL1: begin
                  if (kind_reg == ee_pkg::CMD_POLL) begin
                    state_reg <= ee_pkg::MS_STOP;
                  end else if (kind_reg == ee_pkg::CMD_READ_CUR) begin
                    state_reg <= ee_pkg::MS_RX;
                  end else begin
                    tx_reg <= addr_reg;
                    step_reg <= ee_pkg::STEP_ADDR;
                  end
                end
                ee_pkg::STEP_ADDR: begin
                  if (is_write) begin
                    tx_reg <= wr_data;
                    step_reg <= ee_pkg::STEP_DATA;
                  end else begin
                    step_reg <= ee_pkg::STEP_CTRL2;
                    state_reg <= ee_pkg::MS_START;
                  end
                end
                ee_pkg::STEP_DATA: begin
                  if (left_reg == 4'h0) begin
                    state_reg <= ee_pkg::MS_STOP;
                  end else begin
                    tx_reg <= wr_data;
                    left_reg <= left_reg - 4'h1;
                  end
                end
                ee_pkg::STEP_CTRL2: state_reg <= ee_pkg::MS_RX;
              endcase
            end
          end
          ee_pkg::MS_RX: begin
            if (!ack_slot) begin
              rx_reg <= {rx_reg[6:0], sda_in};
              bcnt_reg <= bcnt_reg + 4'h1;
              if (bcnt_reg == 4'h7) begin
                rd_data_reg <= {rx_reg[6:0], sda_in};
                rd_valid_reg <= 1'b1;
              end
            end else begin
              bcnt_reg <= 4'h0;
              if (left_reg == 4'h0) begin
                state_reg <= ee_pkg::MS_STOP;
              end else begin
                left_reg <= left_reg - 4'h1;
              end
            end
          end
          ee_pkg::MS_STOP: begin
            state_reg <= ee_pkg::MS_IDLE;
            done_reg <= 1'b1;
          end
          default: state_reg <= ee_pkg::MS_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/ee_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ee_link_sva #(
  parameter int unsigned WRITE_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic sup_rst,
  input wire logic busy,
  input wire logic scl,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic sda
);
  // Length of the current programming cycle in system clocks
  logic [31:0] busy_cnt_reg;
  logic [31:0] busy_cnt_next;

  assign busy_cnt_next = busy ? busy_cnt_reg + 32'h1 : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  property p_sup_quiet;
    @(posedge link_clk) disable iff (rst) sup_rst [*4] |-> !s_sda_oe;
  endproperty
  a_sup_quiet: assert property (p_sup_quiet)
    else $error("device drives sda in supervisory reset");

  property p_busy_quiet;
    @(posedge link_clk) disable iff (rst) busy [*4] |-> !s_sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device drives sda while programming");

  property p_hold_scl_high;
    @(posedge link_clk) disable iff (rst) scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_hold_scl_high: assert property (p_hold_scl_high)
    else $error("device changed sda with scl high");

  property p_no_fight;
    @(posedge link_clk) disable iff (rst) scl && s_sda_oe |-> !m_sda_oe;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive sda in one bit");

  property p_stop_release;
    @(posedge link_clk) disable iff (rst) scl && $rose(sda) |-> !s_sda_oe [*8];
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("device drives sda after stop");

  property p_busy_max;
    @(posedge clk) disable iff (rst) busy |-> busy_cnt_reg < WRITE_CYCLES + 32;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("programming cycle too long");

  property p_busy_min;
    @(posedge clk) disable iff (rst) $fell(busy) |-> busy_cnt_reg + 32'h1 >= WRITE_CYCLES;
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("programming cycle too short");

  property p_commit_idle;
    @(posedge clk) disable iff (rst) $rose(busy) |-> scl && sda;
  endproperty
  a_commit_idle: assert property (p_commit_idle)
    else $error("programming began with bus not idle");

  property p_sup_no_prog;
    @(posedge link_clk) disable iff (rst) sup_rst [*6] |-> !$rose(busy);
  endproperty
  a_sup_no_prog: assert property (p_sup_no_prog)
    else $error("programming began in supervisory reset");
endmodule
`default_nettype wire

// ===== sim/i2c_eeprom_slave_2kbit_test.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_slave_2kbit_test;
  localparam int unsigned WCYC = 8000;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic sup_rst;
  logic cmd_valid;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_addr;
  logic [3:0] cmd_len;
  logic [7:0] wr_data;
  logic cmd_ready, wr_take, rd_valid, done, nack, busy;
  logic [7:0] rd_data;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  logic [1:0] nq[$];
  logic [1:0] note;
  logic [7:0] d[4];
  int fail_count = 0;
  int n_checks = 0;
  int n;

  always #2.5 clk = ~clk;
  always #16 link_clk = ~link_clk;

  ee_link_if link();

  ee_master u_ee_master (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .nack(nack));

  ee_device #(.WRITE_CYCLES(WCYC)) u_ee_device (.clk(clk), .rst(rst), .link_clk(link_clk),
    .sup_rst(sup_rst), .busy(busy), .link(link));

  ee_link_sva #(.WRITE_CYCLES(WCYC)) u_ee_link_sva (.clk(clk), .rst(rst),
    .link_clk(link_clk), .sup_rst(sup_rst), .busy(busy), .scl(link.scl),
    .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe), .sda(link.sda));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic [1:0] kind, input logic [7:0] addr, input logic [3:0] len);
    @(posedge clk);
    #1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    cmd_kind = kind;
    cmd_addr = addr;
    cmd_len = len;
    wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // A command that never finishes counts against the run
    if (n >= 40000) begin
      fail_count++;
    end
  endtask

  task automatic write2(input logic [7:0] addr, input int first);
    wq.push_back(d[first]);
    wq.push_back(d[first + 1]);
    nq.push_back(2'h2);
    run_cmd(ee_pkg::CMD_WRITE, addr, 4'h1);
    check(8'(wq.size()), 8'h00);
  endtask

  // Next write byte is presented once the current one has been taken
  always @(negedge clk) begin
    if (wr_take === 1'b1) begin
      void'(wq.pop_front());
      @(posedge clk);
      #1;
      wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
    end
  end

  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      check(rd_data, (rq.size() > 0) ? rq.pop_front() : 8'hxx);
    end
    if (done === 1'b1) begin
      note = (nq.size() > 0) ? nq.pop_front() : 2'h2;
      if (note[1]) begin
        check({7'h00, nack}, {7'h00, note[0]});
      end
    end
  end

  initial begin
    #490000;
    fail_count++;
    end_of_test();
  end

  initial begin
    sup_rst = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 8'h00;
    cmd_len = 4'h0;
    wr_data = 8'h00;
    void'($urandom(32'h50b11143));
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom());
    end
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge link_clk);
    write2(8'h00, 0);
    nq.push_back(2'h3);
    run_cmd(ee_pkg::CMD_POLL, 8'h00, 4'h0);
    nq.push_back(2'h2);
    run_cmd(ee_pkg::CMD_POLL, 8'h00, 4'h0);
    // Two bytes from the page end: the second lands at the page start
    write2(8'hff, 2);
    @(posedge clk);
    #1;
    sup_rst = 1'b1;
    check({7'h00, busy}, 8'h01);
    nq.push_back(2'h3);
    run_cmd(ee_pkg::CMD_POLL, 8'h00, 4'h0);
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h00, busy}, 8'h00);
    sup_rst = 1'b0;
    repeat (4) @(posedge link_clk);
    rq.push_back(d[2]);
    rq.push_back(d[0]);
    nq.push_back(2'h2);
    run_cmd(ee_pkg::CMD_READ_RAND, 8'hff, 4'h1);
    rq.push_back(d[1]);
    nq.push_back(2'h2);
    run_cmd(ee_pkg::CMD_READ_CUR, 8'h00, 4'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
